// ===== st_line_activation_fsm.sv
`timescale 1ns/1ps
module st_line_activation_fsm #(
   parameter int INFO0_CYCLES = st_act_pkg::INFO0_CYC,
   parameter int DEACT_CYCLES = st_act_pkg::DEACT_CYC
) (
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   // Configuration
   input  wire logic                 networkTermMode,
   input  wire logic                 codeViolationCheckEnable,
   input  wire logic                 clockStopSelect,
   // Command/indicate channel
   input  wire logic [3:0]           ciCmd,
   output logic      [3:0]           ciInd,
   // Line receiver status and transmit control
   input  wire st_act_pkg::line_rx_t lineRx,
   output st_act_pkg::line_tx_t      lineTx,
   output st_act_pkg::act_state_t    actState
);
   typedef st_act_pkg::act_state_t state_t;

   state_t                 state_r;
   state_t                 stateNxt;
   logic [st_act_pkg::TMR_W-1:0] deaTmr_r;
   logic [st_act_pkg::TMR_W-1:0] i0Tmr_r;
   logic [3:0]             indNxt;
   st_act_pkg::line_tx_t   txNxt;

   wire  nt       = networkTermMode;
   wire  inTest   = (state_r == st_act_pkg::ST_TEST_SP) || (state_r == st_act_pkg::ST_TEST_CP);
   wire  cmdLoop  = (ciCmd == st_act_pkg::CMD_LOOP_REQ);
   wire  i0Done   = i0Tmr_r >= INFO0_CYCLES[st_act_pkg::TMR_W-1:0] - 1'b1;
   wire  deaDone  = deaTmr_r >= DEACT_CYCLES[st_act_pkg::TMR_W-1:0] - 1'b1;
   wire  cvReport = codeViolationCheckEnable && lineRx.codeViol;

   // Clear, test and deactivation request commands first, then per-state transitions
   always_comb begin
      stateNxt = state_r;
      if (ciCmd == st_act_pkg::CMD_CLEAR) begin
         stateNxt = st_act_pkg::ST_RESET;
      end else if (ciCmd == st_act_pkg::CMD_SSP && !inTest) begin
         stateNxt = st_act_pkg::ST_TEST_SP;
      end else if (ciCmd == st_act_pkg::CMD_SCP && !inTest) begin
         stateNxt = st_act_pkg::ST_TEST_CP;
      end else if (ciCmd == st_act_pkg::CMD_DEACT_REQ &&
                   state_r != st_act_pkg::ST_PEND_DEA && state_r != st_act_pkg::ST_WAIT_DR &&
                   (nt || state_r != st_act_pkg::ST_DEACT)) begin
         stateNxt = st_act_pkg::ST_PEND_DEA;
      end else begin
         unique case (state_r)
            st_act_pkg::ST_RESET, st_act_pkg::ST_TEST_SP, st_act_pkg::ST_TEST_CP: begin
               if (ciCmd == st_act_pkg::CMD_DEACT_CONF) stateNxt = st_act_pkg::ST_DEACT;
            end
            st_act_pkg::ST_DEACT: begin
               if (ciCmd == st_act_pkg::CMD_ACT_REQ || cmdLoop)
                  stateNxt = st_act_pkg::ST_PEND_ACT;
               else if (lineRx.info0Det)
                  stateNxt = nt ? st_act_pkg::ST_I0_DET : st_act_pkg::ST_PEND_ACT;
            end
            st_act_pkg::ST_I0_DET: begin
               if (ciCmd == st_act_pkg::CMD_ACT_REQ || cmdLoop)
                  stateNxt = st_act_pkg::ST_PEND_ACT;
            end
            st_act_pkg::ST_PEND_ACT: begin
               if (lineRx.info3Det)
                  stateNxt = nt ? st_act_pkg::ST_WAIT_SW : st_act_pkg::ST_ACTIVE;
            end
            st_act_pkg::ST_WAIT_SW: begin
               if (ciCmd == st_act_pkg::CMD_SWITCH || ciCmd == st_act_pkg::CMD_LOOP_IND)
                  stateNxt = st_act_pkg::ST_ACTIVE;
            end
            st_act_pkg::ST_ACTIVE: begin
               if (!lineRx.rxSync)
                  stateNxt = st_act_pkg::ST_LOST_LINE;
               else if (nt && ciCmd == st_act_pkg::CMD_UNSYNC)
                  stateNxt = st_act_pkg::ST_LOST_UP;
            end
            st_act_pkg::ST_LOST_LINE: begin
               if (lineRx.info3Det && lineRx.rxSync)
                  stateNxt = nt ? st_act_pkg::ST_WAIT_SW : st_act_pkg::ST_ACTIVE;
            end
            st_act_pkg::ST_LOST_UP: begin
               if (ciCmd == st_act_pkg::CMD_SWITCH || ciCmd == st_act_pkg::CMD_LOOP_IND)
                  stateNxt = st_act_pkg::ST_ACTIVE;
            end
            st_act_pkg::ST_PEND_DEA: begin
               if (i0Done || deaDone) stateNxt = st_act_pkg::ST_WAIT_DR;
            end
            st_act_pkg::ST_WAIT_DR: begin
               if (ciCmd == st_act_pkg::CMD_DEACT_CONF) stateNxt = st_act_pkg::ST_DEACT;
            end
            default: stateNxt = st_act_pkg::ST_RESET;
         endcase
      end
   end

   // Indication and transmit selection for the next state
   always_comb begin
      indNxt = st_act_pkg::IND_NONE;
      txNxt  = '{txInfo: st_act_pkg::TX_INFO0, loopClosed: 1'b0, transparent: 1'b0,
                 clockStop: 1'b0};
      unique case (stateNxt)
         st_act_pkg::ST_DEACT: begin
            indNxt = nt ? st_act_pkg::IND_DEACT_DONE : st_act_pkg::IND_TIMING;
            txNxt.clockStop = clockStopSelect;
         end
         st_act_pkg::ST_I0_DET: indNxt = st_act_pkg::IND_ACT_REQ;
         st_act_pkg::ST_PEND_ACT, st_act_pkg::ST_WAIT_SW, st_act_pkg::ST_LOST_UP: begin
            indNxt = lineRx.info0Det ? st_act_pkg::IND_ACT_REQ : st_act_pkg::IND_UNSYNC;
            txNxt.txInfo = st_act_pkg::TX_INFO2;
         end
         st_act_pkg::ST_ACTIVE: begin
            indNxt = st_act_pkg::IND_SYNC_DONE;
            txNxt.txInfo      = st_act_pkg::TX_INFO4;
            txNxt.transparent = 1'b1;
         end
         st_act_pkg::ST_LOST_LINE: begin
            indNxt = st_act_pkg::IND_UNSYNC;
            txNxt.txInfo = st_act_pkg::TX_INFO2;
         end
         st_act_pkg::ST_PEND_DEA: indNxt = st_act_pkg::IND_TIMING;
         st_act_pkg::ST_WAIT_DR:  indNxt = st_act_pkg::IND_DEACT_DONE;
         st_act_pkg::ST_TEST_SP:  txNxt.txInfo = st_act_pkg::TX_SINGLE;
         st_act_pkg::ST_TEST_CP:  txNxt.txInfo = st_act_pkg::TX_CONT;
         default: indNxt = st_act_pkg::IND_NONE;
      endcase
      // Loop 2 held while loop request stays applied in pending activation or active, or loop indication into active in network termination mode
      if (cmdLoop && (stateNxt == st_act_pkg::ST_PEND_ACT || stateNxt == st_act_pkg::ST_ACTIVE))
         txNxt.loopClosed = 1'b1;
      if (nt && ciCmd == st_act_pkg::CMD_LOOP_IND && stateNxt == st_act_pkg::ST_ACTIVE)
         txNxt.loopClosed = 1'b1;
      if (cvReport && stateNxt != st_act_pkg::ST_RESET && stateNxt != st_act_pkg::ST_WAIT_DR)
         indNxt = st_act_pkg::IND_CODE_VIOL;
      if (!lineRx.rxSync && lineRx.levelDet && stateNxt == st_act_pkg::ST_PEND_ACT)
         indNxt = st_act_pkg::IND_UNSYNC;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= st_act_pkg::ST_RESET;
         ciInd   <= st_act_pkg::IND_NONE;
         lineTx  <= '{txInfo: st_act_pkg::TX_INFO0, loopClosed: 1'b0, transparent: 1'b0,
                      clockStop: 1'b0};
      end else begin
         state_r <= stateNxt;
         ciInd   <= indNxt;
         lineTx  <= txNxt;
      end
   end

   assign actState = state_r;

   // Deactivation timers run only in pending deactivation
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         deaTmr_r <= '0;
         i0Tmr_r  <= '0;
      end else if (state_r != st_act_pkg::ST_PEND_DEA) begin
         deaTmr_r <= '0;
         i0Tmr_r  <= '0;
      end else begin
         deaTmr_r <= deaTmr_r + 1'b1;
         i0Tmr_r  <= lineRx.info0Det ? i0Tmr_r + 1'b1 : '0;
      end
   end
endmodule : st_line_activation_fsm

// ===== st_act_pkg.sv
package st_act_pkg;
   localparam logic [3:0] CMD_DEACT_REQ  = 4'h0;
   localparam logic [3:0] CMD_CLEAR      = 4'h1;
   localparam logic [3:0] CMD_SSP        = 4'h2;
   localparam logic [3:0] CMD_SCP        = 4'h3;
   localparam logic [3:0] CMD_UNSYNC     = 4'h4;
   localparam logic [3:0] CMD_ACT_REQ    = 4'h8;
   localparam logic [3:0] CMD_LOOP_REQ   = 4'ha;
   localparam logic [3:0] CMD_SWITCH     = 4'hc;
   localparam logic [3:0] CMD_LOOP_IND   = 4'he;
   localparam logic [3:0] CMD_DEACT_CONF = 4'hf;
   localparam logic [3:0] IND_TIMING     = 4'h0;
   localparam logic [3:0] IND_UNSYNC     = 4'h4;
   localparam logic [3:0] IND_ACT_REQ    = 4'h8;
   localparam logic [3:0] IND_CODE_VIOL  = 4'hb;
   localparam logic [3:0] IND_SYNC_DONE  = 4'hc;
   localparam logic [3:0] IND_DEACT_DONE = 4'hf;
   localparam logic [3:0] IND_NONE       = 4'h6;
   localparam int         CLK_HZ         = 10000000;
   localparam int         INFO0_MS       = 16;
   localparam int         DEACT_MS       = 32;
   localparam int         INFO0_CYC      = CLK_HZ / 1000 * INFO0_MS;
   localparam int         DEACT_CYC      = CLK_HZ / 1000 * DEACT_MS;
   localparam int         TMR_W          = 20;

   typedef enum logic [2:0] {
      TX_INFO0  = 3'h0,
      TX_INFO2  = 3'h2,
      TX_INFO4  = 3'h4,
      TX_SINGLE = 3'h5,
      TX_CONT   = 3'h6
   } tx_info_t;

   typedef enum logic [3:0] {
      ST_RESET     = 4'h0,
      ST_DEACT     = 4'h1,
      ST_I0_DET    = 4'h2,
      ST_PEND_ACT  = 4'h3,
      ST_WAIT_SW   = 4'h4,
      ST_ACTIVE    = 4'h5,
      ST_LOST_LINE = 4'h6,
      ST_LOST_UP   = 4'h7,
      ST_PEND_DEA  = 4'h8,
      ST_WAIT_DR   = 4'h9,
      ST_TEST_SP   = 4'ha,
      ST_TEST_CP   = 4'hb
   } act_state_t;

   typedef struct packed {
      logic info0Det;
      logic levelDet;
      logic info3Det;
      logic rxSync;
      logic codeViol;
   } line_rx_t;

   typedef struct packed {
      tx_info_t txInfo;
      logic     loopClosed;
      logic     transparent;
      logic     clockStop;
   } line_tx_t;
endpackage : st_act_pkg

// ===== st_act_checker.sv
`timescale 1ns/1ps
module st_act_checker #(
   parameter int INFO0_CYCLES = 16,
   parameter int DEACT_CYCLES = 32
) (
   // Clock, reset, configuration
   input wire logic                   core_clk,
   input wire logic                   sys_rst,
   input wire logic                   networkTermMode,
   input wire logic                   codeViolationCheckEnable,
   input wire logic                   clockStopSelect,
   // Command channel and line
   input wire logic [3:0]             ciCmd,
   input wire logic [3:0]             ciInd,
   input wire st_act_pkg::line_rx_t   lineRx,
   input wire st_act_pkg::line_tx_t   lineTx,
   input wire st_act_pkg::act_state_t actState
);
   logic [31:0] pendCnt_r;
   wire         inTest = actState inside {st_act_pkg::ST_TEST_SP, st_act_pkg::ST_TEST_CP};
   wire         inWait = actState == st_act_pkg::ST_WAIT_DR;
   wire         inAct  = actState == st_act_pkg::ST_ACTIVE;
   wire [2:0]   tx     = lineTx.txInfo;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Counts time spent pending so a stuck timer cannot hide
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         pendCnt_r <= '0;
      else
         pendCnt_r <= actState == st_act_pkg::ST_PEND_DEA ? pendCnt_r + 1 : '0;
   end
   a_clear_resets: assert property (
      ciCmd == 4'h1 |=> actState == st_act_pkg::ST_RESET && tx == 3'h0) else $error("no clear");
   a_nt_deact: assert property (
      networkTermMode && ciCmd == 4'h0 |=> tx == 3'h0) else $error("no info0");
   a_test_entry: assert property (
      ciCmd[3:1] == 3'h1 && !inTest |=> tx == ($past(ciCmd[0]) ? 3'h6 : 3'h5))
      else $error("bad test tx");
   a_host_act: assert property (
      !networkTermMode && actState == st_act_pkg::ST_DEACT && ciCmd == 4'h8 |=> tx == 3'h2)
      else $error("no info2");
   a_viol_gated: assert property (
      !codeViolationCheckEnable [*2] |-> ciInd != 4'hb) else $error("ungated viol");
   a_active_out: assert property (
      inAct && ciInd != 4'hb |-> ciInd == 4'hc && tx == 3'h4 && lineTx.transparent)
      else $error("bad active out");
   a_pend_bound: assert property (
      pendCnt_r <= DEACT_CYCLES + 1) else $error("pending too long");
   a_wait_holds: assert property (
      inWait && ciCmd == 4'h0 |=> inWait && ciInd == 4'hf) else $error("left wait");
   a_confirm_deact: assert property (
      inWait && ciCmd == 4'hf |=> actState == st_act_pkg::ST_DEACT && tx == 3'h0)
      else $error("no deact");
   a_sync_lost: assert property (
      inAct && !lineRx.rxSync && ciCmd inside {4'h8, 4'hc} |=> actState == st_act_pkg::ST_LOST_LINE)
      else $error("no lost framing");
   c_active: cover property (inAct);
   c_wait: cover property (inWait);
   c_test: cover property (inTest);
endmodule : st_act_checker
bind st_line_activation_fsm st_act_checker #(.INFO0_CYCLES(INFO0_CYCLES),
   .DEACT_CYCLES(DEACT_CYCLES)) chk (.*);

// ===== line_terminal_model.sv
`timescale 1ns/1ps
module line_terminal_model (
   // Clock and line from the device
   input  wire logic                 core_clk,
   input  wire st_act_pkg::line_tx_t lineTx,
   // Terminal behaviour set by the bench
   input  wire logic                 termOn,
   input  wire logic                 syncOk,
   input  wire logic                 cvErr,
   output st_act_pkg::line_rx_t      lineRx
);
   wire heard = lineTx.txInfo inside {st_act_pkg::TX_INFO2, st_act_pkg::TX_INFO4};
   // A powered terminal answers a framed line one cycle late
   always_ff @(posedge core_clk) begin
      lineRx <= {termOn, termOn, termOn && heard, termOn && heard && syncOk, cvErr};
   end
endmodule : line_terminal_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
   logic                   core_clk = 0, sys_rst = 1, networkTermMode = 0, clockStopSelect = 0;
   logic                   codeViolationCheckEnable = 0, termOn = 0, syncOk = 1, cvErr = 0;
   logic [3:0]             ciCmd = 4'h1;
   logic [3:0]             ciInd;
   st_act_pkg::line_rx_t   lineRx;
   st_act_pkg::line_tx_t   lineTx;
   st_act_pkg::act_state_t actState;
   logic [31:0]            seed = 32'h4f;
   logic [3:0]             pool [8] = '{4'h0, 4'h1, 4'h4, 4'h8, 4'ha, 4'hc, 4'he, 4'hf};
   int                     nErrors = 0, nCompared = 0, cycles = 0, n, m;
   always #50 core_clk = ~core_clk;
   st_line_activation_fsm #(.INFO0_CYCLES(16), .DEACT_CYCLES(32)) dut (.*);
   line_terminal_model term (.*);
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   function automatic int pendLen(input logic heard);
      return heard ? 16 : 32;
   endfunction : pendLen
   task automatic tallyAndFinish;
      $display("errors %0d compared %0d", nErrors, nCompared);
      if (nErrors == 0 && nCompared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tallyAndFinish
   task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      nCompared++;
      if (seen !== exp) begin
         nErrors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cmd(input logic [3:0] c, input int k);
      ciCmd = c;
      repeat (k) @(negedge core_clk);
   endtask : cmd
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         nErrors++;
         tallyAndFinish();
      end
   end
   initial begin
      repeat (20) @(negedge core_clk);
      sys_rst = 0;
      chk("reset", {actState, ciInd}, {st_act_pkg::ST_RESET, 4'h6});
      for (m = 0; m < 2; m++) begin
         termOn = 0;
         seed = xs(seed);
         clockStopSelect = seed[0];
         cmd(4'hf, 3);
         chk("deact", {actState, ciInd, lineTx.clockStop},
             {st_act_pkg::ST_DEACT, 4'h0, clockStopSelect});
         cmd(4'h8, 1);
         chk("act start", lineTx.txInfo, 3'h2);
         termOn = 1;
         cmd(4'h8, 4);
         chk("active", {ciInd, lineTx.txInfo, lineTx.transparent}, {4'hc, 3'h4, 1'b1});
         repeat (4) begin
            seed = xs(seed);
            {codeViolationCheckEnable, cvErr} = seed[2:1];
            cmd(4'h8, 2);
            chk("viol", ciInd == 4'hb, codeViolationCheckEnable && cvErr);
         end
         {cvErr, syncOk} = 2'h0;
         cmd(4'h8, 3);
         chk("lost", actState, st_act_pkg::ST_LOST_LINE);
         chk("lost ind", ciInd, 4'h4);
         {syncOk, termOn} = {1'b1, m[0]};
         cmd(4'h0, 1);
         chk("deact tx", lineTx.txInfo, 3'h0);
         for (n = 1; actState == st_act_pkg::ST_PEND_DEA && n < 40; n++)
            @(negedge core_clk);
         chk("pend len", n >= pendLen(m[0]) - 1 && n <= pendLen(m[0]) + 1, 1'b1);
         chk("done", {actState, ciInd}, {st_act_pkg::ST_WAIT_DR, 4'hf});
         cmd(4'h0, 4);
         chk("wait dr", actState, st_act_pkg::ST_WAIT_DR);
      end
      termOn = 0;
      for (n = 2; n < 4; n++) begin
         cmd(4'hf, 2);
         cmd(n[3:0], 2);
         chk("test tx", lineTx.txInfo, n[0] ? 3'h6 : 3'h5);
      end
      networkTermMode = 1;
      cmd(4'hf, 2);
      termOn = 1;
      cmd(4'hf, 4);
      chk("nt detect", {actState, ciInd}, {st_act_pkg::ST_I0_DET, 4'h8});
      cmd(4'h8, 1);
      chk("nt pend", {actState, lineTx.txInfo}, {st_act_pkg::ST_PEND_ACT, 3'h2});
      cmd(4'ha, 1);
      chk("loop two", lineTx.loopClosed, 1'b1);
      cmd(4'h8, 3);
      chk("nt wait", {actState, lineTx.txInfo}, {st_act_pkg::ST_WAIT_SW, 3'h2});
      cmd(4'he, 2);
      chk("nt loop", {actState, lineTx.loopClosed}, {st_act_pkg::ST_ACTIVE, 1'b1});
      cmd(4'h4, 2);
      chk("nt unsync", lineTx.txInfo, 3'h2);
      cmd(4'h1, 4);
      chk("clear", {actState, lineTx.txInfo}, {st_act_pkg::ST_RESET, 3'h0});
      // Pool leaves out test codes so two never follow each other
      repeat (60) begin
         seed = xs(seed);
         {termOn, syncOk, cvErr, codeViolationCheckEnable} = seed[7:4];
         cmd(pool[seed[2:0]], 1 + int'(seed[9:8]));
      end
      tallyAndFinish();
   end
endmodule : tb
